// *** rtc_bus_master.sv ***
// Behavioural bus master standing in for the two-wire controller.
// Drives the request struct just after ref_clk edges, one request per two cycles.
`timescale 1ns/1ps
module rtc_bus_master (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rd_data,
  output rtc_pkg::rtc_reg_req_type reg_req
);
  initial reg_req = '0;

  // Released lines show inverted values, not the last ones
  task automatic issue(input logic [2:0] kind, input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    reg_req <= '{start: kind[2], wr: kind[1], rd: kind[0], addr: addr, data: data};
    @(posedge ref_clk);
    reg_req <= '{start: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
  endtask

  task automatic snapshot();
    issue(3'b100, 8'h00, 8'h00);
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    issue(3'b010, addr, data);
  endtask

  // Answer taken one core cycle after the request, far above any timer rate
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    issue(3'b001, addr, 8'h00);
    @(posedge ref_clk);
    data = reg_rd_data;
  endtask
endmodule // rtc_bus_master

// *** rtc_core.sv ***
// Calendar, alarm, countdown timer and square-wave core of the serial real-time clock.
// Assumes the two-wire engine on ref_clk presents register requests and the START event.
//
// Operation
// - Either test bit in test_control set puts the device in test mode.
// - In test mode the hold bit keeps all dividers at zero.
// - Pulse mode off: interrupt held low while timer flag is set.
// - Pulse mode on: interrupt pulse length depends on timer rate and reload.
// - Timer flag and interrupt become active in the same cycle.
// - Countdown stays stopped while the reload value is zero.
// - Alarm match sets alarm flag; only software clears it.
// - Timer expiry sets timer flag; writing 0 clears, 1 keeps.
// - Alarm drives the interrupt only with alarm interrupt enable set.
// - Timer drives the interrupt only with timer interrupt enable set.
// - Square-wave output is driven only while its enable bit is 1.
// - Rate field picks 32768, 8192, 4096 or 1 Hz square wave.
// - Eight-bit down-counter clocked only while countdown_run is 1.
// - Timer clock field picks 4096, 64, 1 or 1/60 Hz.
// - Countdown value register holds reload value n; reads here return the running count instead.
// - Bit 7 of seconds reports the low-supply flag.
// - Seconds, minutes 00-59 and hours 00-23 counted in BCD.
// - Date counts 01-31 in BCD, weekday 0-6.
// - Month counts BCD 01-12 in bits 4:0.
// - Century bit toggles when year rolls from 99 to 00.
// - Year counts BCD 00-99 in eight bits.
// - Power-up clears registers except the listed bits, which are set.
// - Bus START copies counters into shadow; reads come from the shadow.
// - Alarm field takes part in match only while its disable bit is 0.

`timescale 1ns/1ps
`include "rtc_params.svh"

module rtc_core (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic osc_clk,
  input wire logic supply_low,
  input rtc_pkg::rtc_reg_req_type reg_req,
  output logic [7:0] reg_rd_data,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic square_wave_out,
  output logic square_wave_out_oe,
  output logic test_mode
);

  rtc_pkg::rtc_state_type s;
  rtc_pkg::rtc_state_type next_s;

  // BCD increment with wrap to lo after hi; returns {carry, value}
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] r;
    r = 8'h00;
    if (v >= hi) begin
      return {1'b1, lo};
    end
    if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {1'b0, r};
  endfunction

  // Last day of a BCD month, leap February when year divisible by four
  function automatic logic [7:0] last_day(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month[4:0])
      5'h02: last_day = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // Register image read, time registers from the shadow copy
  function automatic logic [7:0] read_reg(input rtc_pkg::rtc_state_type st, input logic [7:0] addr);
    case (addr)
      `RTC_ADDR_TEST_CONTROL: read_reg = st.test_control;
      `RTC_ADDR_IRQ_CONTROL: read_reg = st.irq_control;
      `RTC_ADDR_SECONDS: read_reg = st.shadow.seconds;
      `RTC_ADDR_MINUTES: read_reg = st.shadow.minutes;
      `RTC_ADDR_HOURS: read_reg = st.shadow.hours;
      `RTC_ADDR_DAY_OF_MONTH: read_reg = st.shadow.date;
      `RTC_ADDR_DAY_OF_WEEK: read_reg = st.shadow.weekday;
      `RTC_ADDR_MONTH: read_reg = st.shadow.month;
      `RTC_ADDR_YEAR: read_reg = st.shadow.year;
      `RTC_ADDR_ALARM_MINUTE: read_reg = st.alarm[0];
      `RTC_ADDR_ALARM_HOUR: read_reg = st.alarm[1];
      `RTC_ADDR_ALARM_DATE: read_reg = st.alarm[2];
      `RTC_ADDR_ALARM_WEEKDAY: read_reg = st.alarm[3];
      `RTC_ADDR_SQUARE_CONTROL: read_reg = st.square_control;
      `RTC_ADDR_COUNTDOWN_CONTROL: read_reg = st.countdown_control;
      `RTC_ADDR_COUNTDOWN_VALUE: read_reg = st.countdown_count;
      default: read_reg = 8'h00;
    endcase
  endfunction

  logic osc_tick;
  logic hold_dividers;
  logic tick_4096;
  logic tick_64;
  logic tick_1;
  logic tick_minute;
  logic timer_tick;
  logic timer_expire;
  logic alarm_match;
  logic alarm_set;
  logic low_set;
  logic wr_ctl2;
  logic square_level;
  logic [8:0] step;
  logic carry;
  logic [9:0] pulse_len;
  rtc_pkg::rtc_time_type t;

  always_comb begin
    next_s = s;
    step = 9'h000;
    carry = 1'b0;
    pulse_len = 10'h000;
    alarm_match = 1'b0;
    alarm_set = 1'b0;
    timer_tick = 1'b0;
    timer_expire = 1'b0;

    // Pin synchronisers; edge detect reads only the second stage and later
    next_s.osc_s1 = osc_clk;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_s3 = s.osc_s2;
    next_s.low_s1 = supply_low;
    next_s.low_s2 = s.low_s1;
    osc_tick = s.osc_s2 & ~s.osc_s3;

    test_mode = s.test_control[`RTC_BIT_TEST_MODE_A] | s.test_control[`RTC_BIT_TEST_MODE_B];
    hold_dividers = test_mode & s.test_control[`RTC_BIT_DIVIDER_HOLD];

    if (hold_dividers) begin
      next_s.divider = 15'h0000;
    end else if (osc_tick) begin
      next_s.divider = s.divider + 15'h0001;
    end
    tick_4096 = osc_tick & ~hold_dividers & ((s.divider & `RTC_DIV_MASK_4096_HZ) == `RTC_DIV_MASK_4096_HZ);
    tick_64 = osc_tick & ~hold_dividers & ((s.divider & `RTC_DIV_MASK_64_HZ) == `RTC_DIV_MASK_64_HZ);
    tick_1 = osc_tick & ~hold_dividers & (&s.divider);
    tick_minute = tick_1 & (s.counters.seconds[6:0] == `RTC_BCD_59);

    // Calendar chain
    t = s.counters;
    if (tick_1) begin
      step = bcd_step({1'b0, s.counters.seconds[6:0]}, 8'h00, `RTC_BCD_59);
      t.seconds = {s.counters.seconds[`RTC_BIT_LOW_SUPPLY], step[6:0]};
      carry = step[8];
      if (carry) begin
        step = bcd_step(s.counters.minutes, 8'h00, `RTC_BCD_59);
        t.minutes = step[7:0];
        carry = step[8];
      end
      if (carry) begin
        step = bcd_step(s.counters.hours, 8'h00, `RTC_BCD_23);
        t.hours = step[7:0];
        carry = step[8];
      end
      if (carry) begin
        t.weekday = (s.counters.weekday >= `RTC_WEEKDAY_LAST) ? 8'h00 : s.counters.weekday + 8'h01;
        step = bcd_step(s.counters.date, 8'h01, last_day(s.counters.month, s.counters.year));
        t.date = step[7:0];
        carry = step[8];
      end
      if (carry) begin
        step = bcd_step({3'b000, s.counters.month[4:0]}, 8'h01, `RTC_BCD_12);
        t.month = {s.counters.month[7:5], step[4:0]};
        carry = step[8];
      end
      if (carry) begin
        step = bcd_step(s.counters.year, 8'h00, `RTC_BCD_99);
        t.year = step[7:0];
        if (step[8]) begin
          t.month[`RTC_BIT_CENTURY] = ~s.counters.month[`RTC_BIT_CENTURY];
        end
      end
      // Alarm fires as a new minute begins on a full match of the enabled fields
      alarm_match = (s.alarm[0][`RTC_BIT_ALARM_FIELD_DISABLE] || s.alarm[0][6:0] == t.minutes[6:0]) &&
                    (s.alarm[1][`RTC_BIT_ALARM_FIELD_DISABLE] || s.alarm[1][5:0] == t.hours[5:0]) &&
                    (s.alarm[2][`RTC_BIT_ALARM_FIELD_DISABLE] || s.alarm[2][5:0] == t.date[5:0]) &&
                    (s.alarm[3][`RTC_BIT_ALARM_FIELD_DISABLE] || s.alarm[3][2:0] == t.weekday[2:0]);
      alarm_set = alarm_match && (t.seconds[6:0] == 7'h00) &&
                  !(s.alarm[0][7] && s.alarm[1][7] && s.alarm[2][7] && s.alarm[3][7]);
    end
    next_s.counters = t;

    // Countdown timer
    case (rtc_pkg::rtc_timer_rate_type'(s.countdown_control[1:0]))
      rtc_pkg::RTC_RATE_4096_HZ: begin
        timer_tick = tick_4096;
        pulse_len = (s.countdown_value == 8'h01) ? 10'(`RTC_PULSE_HALF_4096_HZ) : 10'(`RTC_PULSE_FULL_4096_HZ);
      end
      rtc_pkg::RTC_RATE_64_HZ: begin
        timer_tick = tick_64;
        pulse_len = (s.countdown_value == 8'h01) ? 10'(`RTC_PULSE_HALF_64_HZ) : 10'(`RTC_PULSE_FULL_64_HZ);
      end
      rtc_pkg::RTC_RATE_1_HZ: begin
        timer_tick = tick_1;
        pulse_len = 10'(`RTC_PULSE_FULL_64_HZ);
      end
      default: begin
        timer_tick = tick_minute;
        pulse_len = 10'(`RTC_PULSE_FULL_64_HZ);
      end
    endcase
    if (s.pulse_count != 10'h000 && osc_tick) begin
      next_s.pulse_count = s.pulse_count - 10'h001;
    end
    if (timer_tick && s.countdown_control[`RTC_BIT_COUNTDOWN_RUN] && s.countdown_value != 8'h00) begin
      if (s.countdown_count <= 8'h01) begin
        timer_expire = 1'b1;
        next_s.countdown_count = s.countdown_value;
        next_s.pulse_count = pulse_len;
      end else begin
        next_s.countdown_count = s.countdown_count - 8'h01;
      end
    end

    // Bus START freezes a copy of the time for reads
    if (reg_req.start) begin
      next_s.shadow = s.counters;
    end
    if (reg_req.rd) begin
      next_s.rd_data = read_reg(s, reg_req.addr);
    end

    // Register writes override the calendar and countdown tick result of the same cycle
    wr_ctl2 = 1'b0;
    if (reg_req.wr) begin
      case (reg_req.addr)
        `RTC_ADDR_TEST_CONTROL: next_s.test_control = reg_req.data & `RTC_MASK_TEST_CONTROL;
        `RTC_ADDR_IRQ_CONTROL: wr_ctl2 = 1'b1;
        `RTC_ADDR_SECONDS: next_s.counters.seconds = reg_req.data;
        `RTC_ADDR_MINUTES: next_s.counters.minutes = reg_req.data & `RTC_MASK_MINUTES;
        `RTC_ADDR_HOURS: next_s.counters.hours = reg_req.data & `RTC_MASK_HOURS;
        `RTC_ADDR_DAY_OF_MONTH: next_s.counters.date = reg_req.data & `RTC_MASK_DATE;
        `RTC_ADDR_DAY_OF_WEEK: next_s.counters.weekday = reg_req.data & `RTC_MASK_WEEKDAY;
        `RTC_ADDR_MONTH: next_s.counters.month = reg_req.data & (`RTC_MASK_MONTH | 8'h80);
        `RTC_ADDR_YEAR: next_s.counters.year = reg_req.data;
        `RTC_ADDR_ALARM_MINUTE: next_s.alarm[0] = reg_req.data & 8'hff;
        `RTC_ADDR_ALARM_HOUR: next_s.alarm[1] = reg_req.data & 8'hbf;
        `RTC_ADDR_ALARM_DATE: next_s.alarm[2] = reg_req.data & 8'hbf;
        `RTC_ADDR_ALARM_WEEKDAY: next_s.alarm[3] = reg_req.data & 8'h87;
        `RTC_ADDR_SQUARE_CONTROL: next_s.square_control = reg_req.data & `RTC_MASK_RATE_CONTROL;
        `RTC_ADDR_COUNTDOWN_CONTROL: next_s.countdown_control = reg_req.data & `RTC_MASK_RATE_CONTROL;
        `RTC_ADDR_COUNTDOWN_VALUE: begin
          next_s.countdown_value = reg_req.data;
          next_s.countdown_count = reg_req.data;
        end
        default: begin
        end
      endcase
    end

    // Low supply is sticky; a detected drop wins over a clearing write
    low_set = s.low_s2;
    if (low_set) begin
      next_s.counters.seconds[`RTC_BIT_LOW_SUPPLY] = 1'b1;
    end

    // Control two: enables from the write, flags set by events win over clears
    if (wr_ctl2) begin
      next_s.irq_control = (reg_req.data & `RTC_MASK_IRQ_CONTROL) | (s.irq_control & 8'h0c);
      if (!reg_req.data[`RTC_BIT_ALARM_FLAG]) begin
        next_s.irq_control[`RTC_BIT_ALARM_FLAG] = 1'b0;
      end
      if (!reg_req.data[`RTC_BIT_TIMER_FLAG]) begin
        next_s.irq_control[`RTC_BIT_TIMER_FLAG] = 1'b0;
      end
    end
    if (alarm_set) begin
      next_s.irq_control[`RTC_BIT_ALARM_FLAG] = 1'b1;
    end
    if (timer_expire) begin
      next_s.irq_control[`RTC_BIT_TIMER_FLAG] = 1'b1;
    end

    // Square-wave level from the synchronised oscillator or the prescaler
    case (rtc_pkg::rtc_square_rate_type'(s.square_control[1:0]))
      rtc_pkg::RTC_SQ_32768_HZ: square_level = s.osc_s2;
      rtc_pkg::RTC_SQ_8192_HZ: square_level = s.divider[1];
      rtc_pkg::RTC_SQ_4096_HZ: square_level = s.divider[2];
      default: square_level = s.divider[14];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s <= '0;
      s.test_control <= `RTC_RESET_TEST_CONTROL;
      s.irq_control <= `RTC_RESET_IRQ_CONTROL;
      s.counters.seconds <= `RTC_RESET_SECONDS;
      s.shadow.seconds <= `RTC_RESET_SECONDS;
      s.alarm <= {4{`RTC_RESET_ALARM}};
      s.square_control <= `RTC_RESET_SQUARE_CONTROL;
      s.countdown_control <= `RTC_RESET_COUNTDOWN_CONTROL;
    end else begin
      s <= next_s;
    end
  end

  // Open-drain outputs drive low only; the enable marks the driven phase
  assign irq_n_out = 1'b0;
  assign irq_n_oe = (s.irq_control[`RTC_BIT_ALARM_FLAG] & s.irq_control[`RTC_BIT_ALARM_IRQ_ENABLE]) |
                    (s.irq_control[`RTC_BIT_TIMER_IRQ_ENABLE] &
                     (s.irq_control[`RTC_BIT_IRQ_PULSE_MODE] ? (s.pulse_count != 10'h000)
                                                              : s.irq_control[`RTC_BIT_TIMER_FLAG]));
  assign square_wave_out = 1'b0;
  assign square_wave_out_oe = s.square_control[`RTC_BIT_SQUARE_ENABLE] & ~square_level;
  assign reg_rd_data = s.rd_data;

endmodule // rtc_core

// *** rtc_core_monitor.sv ***
// Port assertions for the calendar timer core.
// Bound to every rtc_core; sees only its ports.
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_core_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input rtc_pkg::rtc_reg_req_type reg_req,
  input wire logic [7:0] reg_rd_data,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic square_wave_out,
  input wire logic square_wave_out_oe,
  input wire logic test_mode
);
  default clocking mon_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  irq_pin_low_a: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin data not low");
  square_pin_low_a: assert property (square_wave_out == 1'b0)
    else $error("square pin data not low");
  ctl_reserved_a: assert property (
    reg_req.rd && reg_req.addr == `RTC_ADDR_TEST_CONTROL |=> (reg_rd_data & 8'h57) == 8'h00)
    else $error("reserved test control bits not zero");
  test_mode_a: assert property (
    reg_req.wr && reg_req.addr == `RTC_ADDR_TEST_CONTROL
    |=> test_mode == ($past(reg_req.data[7]) | $past(reg_req.data[3])))
    else $error("test mode does not follow its bits");
  read_hold_a: assert property (!reg_req.rd |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
  irq_mask_a: assert property (
    reg_req.wr && reg_req.addr == `RTC_ADDR_IRQ_CONTROL && reg_req.data[1:0] == 2'b00 |=> !irq_n_oe)
    else $error("interrupt active with both enables off");
  rate_readback_a: assert property (
    reg_req.rd && reg_req.addr == `RTC_ADDR_SQUARE_CONTROL && $past(reg_req.wr, 2)
    && $past(reg_req.addr, 2) == `RTC_ADDR_SQUARE_CONTROL
    |=> reg_rd_data == ($past(reg_req.data, 3) & 8'h83))
    else $error("square control readback wrong");
  square_off_a: assert property (
    reg_req.wr && reg_req.addr == `RTC_ADDR_SQUARE_CONTROL && !reg_req.data[7] |=> !square_wave_out_oe)
    else $error("square pin driven while disabled");
endmodule // rtc_core_monitor

bind rtc_core rtc_core_monitor mon (.ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rd_data(reg_rd_data), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .square_wave_out(square_wave_out),
  .square_wave_out_oe(square_wave_out_oe), .test_mode(test_mode));

// *** rtc_params.svh ***
// Offsets, field positions, reset values and timing counts of the calendar timer core.
// Assumes a 25 MHz core clock and a 32.768 kHz oscillator sampled as a plain input.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Register offsets
`define RTC_ADDR_TEST_CONTROL 8'h00
`define RTC_ADDR_IRQ_CONTROL 8'h01
`define RTC_ADDR_SECONDS 8'h02
`define RTC_ADDR_MINUTES 8'h03
`define RTC_ADDR_HOURS 8'h04
`define RTC_ADDR_DAY_OF_MONTH 8'h05
`define RTC_ADDR_DAY_OF_WEEK 8'h06
`define RTC_ADDR_MONTH 8'h07
`define RTC_ADDR_YEAR 8'h08
`define RTC_ADDR_ALARM_MINUTE 8'h09
`define RTC_ADDR_ALARM_HOUR 8'h0a
`define RTC_ADDR_ALARM_DATE 8'h0b
`define RTC_ADDR_ALARM_WEEKDAY 8'h0c
`define RTC_ADDR_SQUARE_CONTROL 8'h0d
`define RTC_ADDR_COUNTDOWN_CONTROL 8'h0e
`define RTC_ADDR_COUNTDOWN_VALUE 8'h0f

// Field positions
`define RTC_BIT_TEST_MODE_A 7
`define RTC_BIT_DIVIDER_HOLD 5
`define RTC_BIT_TEST_MODE_B 3
`define RTC_BIT_IRQ_PULSE_MODE 4
`define RTC_BIT_ALARM_FLAG 3
`define RTC_BIT_TIMER_FLAG 2
`define RTC_BIT_ALARM_IRQ_ENABLE 1
`define RTC_BIT_TIMER_IRQ_ENABLE 0
`define RTC_BIT_LOW_SUPPLY 7
`define RTC_BIT_CENTURY 7
`define RTC_BIT_ALARM_FIELD_DISABLE 7
`define RTC_BIT_SQUARE_ENABLE 7
`define RTC_BIT_COUNTDOWN_RUN 7

// Writable bit masks
`define RTC_MASK_TEST_CONTROL 8'ha8
`define RTC_MASK_IRQ_CONTROL 8'h13
`define RTC_MASK_SECONDS 8'h7f
`define RTC_MASK_MINUTES 8'h7f
`define RTC_MASK_HOURS 8'h3f
`define RTC_MASK_DATE 8'h3f
`define RTC_MASK_WEEKDAY 8'h07
`define RTC_MASK_MONTH 8'h1f
`define RTC_MASK_RATE_CONTROL 8'h83

// Reset values
`define RTC_RESET_TEST_CONTROL 8'h08
`define RTC_RESET_IRQ_CONTROL 8'h00
`define RTC_RESET_SECONDS 8'h80
`define RTC_RESET_ALARM 8'h80
`define RTC_RESET_SQUARE_CONTROL 8'h80
`define RTC_RESET_COUNTDOWN_CONTROL 8'h03

// Calendar limits
`define RTC_BCD_59 8'h59
`define RTC_BCD_23 8'h23
`define RTC_BCD_12 8'h12
`define RTC_BCD_99 8'h99
`define RTC_WEEKDAY_LAST 8'h06

// Oscillator ticks per interval (oscillator runs at 32768 Hz)
`define RTC_OSC_HZ 32768
`define RTC_PULSE_HALF_4096_HZ (`RTC_OSC_HZ / 8192)
`define RTC_PULSE_FULL_4096_HZ (`RTC_OSC_HZ / 4096)
`define RTC_PULSE_HALF_64_HZ (`RTC_OSC_HZ / 128)
`define RTC_PULSE_FULL_64_HZ (`RTC_OSC_HZ / 64)
`define RTC_DIV_MASK_4096_HZ 15'h0007
`define RTC_DIV_MASK_64_HZ 15'h01ff

`endif

// *** rtc_pkg.sv ***
// Types shared by the calendar timer core and its surroundings.
// Widths and encodings are written out here; nothing from rtc_params.svh is used.
package rtc_pkg;

  // Register access from the serial protocol engine, same clock domain
  typedef struct packed {
    logic start;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } rtc_reg_req_type;

  // Time registers in their register image
  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] date;
    logic [7:0] weekday;
    logic [7:0] month;
    logic [7:0] year;
  } rtc_time_type;

  typedef enum logic [1:0] {
    RTC_RATE_4096_HZ = 2'b00,
    RTC_RATE_64_HZ = 2'b01,
    RTC_RATE_1_HZ = 2'b10,
    RTC_RATE_1_60_HZ = 2'b11
  } rtc_timer_rate_type;

  typedef enum logic [1:0] {
    RTC_SQ_32768_HZ = 2'b00,
    RTC_SQ_8192_HZ = 2'b01,
    RTC_SQ_4096_HZ = 2'b10,
    RTC_SQ_1_HZ = 2'b11
  } rtc_square_rate_type;

  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic low_s1;
    logic low_s2;
    logic [14:0] divider;
    rtc_time_type counters;
    rtc_time_type shadow;
    logic [7:0] test_control;
    logic [7:0] irq_control;
    logic [3:0][7:0] alarm;
    logic [7:0] square_control;
    logic [7:0] countdown_control;
    logic [7:0] countdown_value;
    logic [7:0] countdown_count;
    logic [9:0] pulse_count;
    logic [7:0] rd_data;
  } rtc_state_type;

endpackage

// *** testbench.sv ***
// Self-checking bench for the calendar timer core through its register port.
// Assumes rtc_bus_master issues requests and the bound monitor watches the ports.
`timescale 1ns/1ps
`include "rtc_params.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic osc_clk = 1'b0;
  logic supply_low = 1'b0;
  int osc_half = 160;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  logic [7:0] got;
  rtc_pkg::rtc_reg_req_type reg_req;
  logic [7:0] reg_rd_data;
  logic irq_n_out, irq_n_oe, square_wave_out, square_wave_out_oe, test_mode;
  logic [7:0] rst_addr [7] = '{8'h00, 8'h01, 8'h09, 8'h0d, 8'h0e, 8'h0f, 8'h10};
  logic [7:0] rst_val [7] = '{8'h08, 8'h00, 8'h80, 8'h80, 8'h03, 8'h00, 8'h00};
  logic [7:0] cal_set [7] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99};
  logic [7:0] cal_next [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00};
  logic [7:0] tm_wr [3] = '{8'hff, 8'h80, 8'h00};
  logic [7:0] tm_rd [3] = '{8'ha8, 8'h80, 8'h00};
  int sq_exp [4] = '{32, 8, 4, 0};

  always #20 ref_clk = ~ref_clk;
  // Oscillator runs free; sped up from the calendar rollover on
  always #(osc_half) osc_clk = ~osc_clk;

  rtc_core uut (.ref_clk(ref_clk), .resetn(resetn), .osc_clk(osc_clk), .supply_low(supply_low),
    .reg_req(reg_req), .reg_rd_data(reg_rd_data), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .square_wave_out(square_wave_out), .square_wave_out_oe(square_wave_out_oe), .test_mode(test_mode));
  rtc_bus_master master (.ref_clk(ref_clk), .reg_rd_data(reg_rd_data), .reg_req(reg_req));

  task automatic check8(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks_done++;
    if (got_v !== exp_v) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp_v);
    logic [7:0] val;
    master.read_reg(addr, val);
    check8(val, exp_v);
  endtask

  task automatic sq_edges(input int exp_n);
    int cnt;
    logic prev;
    cnt = 0;
    prev = square_wave_out_oe;
    repeat (256) begin
      @(posedge ref_clk);
      if (square_wave_out_oe === 1'b1 && prev === 1'b0) cnt++;
      prev = square_wave_out_oe;
    end
    check8(8'(cnt), 8'(exp_n));
  endtask

  task automatic wait_irq(input logic lvl, input int limit, output int cnt);
    cnt = 0;
    while (irq_n_oe !== lvl && cnt < limit) begin
      @(posedge ref_clk);
      cnt++;
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++) check_reg(rst_addr[i], rst_val[i]);
    master.snapshot();
    check_reg(`RTC_ADDR_SECONDS, 8'h80);
    for (int i = 0; i < 3; i++) begin
      master.write_reg(`RTC_ADDR_TEST_CONTROL, tm_wr[i]);
      check_reg(`RTC_ADDR_TEST_CONTROL, tm_rd[i]);
      check8({7'h00, test_mode}, {7'h00, tm_rd[i] != 8'h00});
    end
    master.write_reg(`RTC_ADDR_TEST_CONTROL, 8'h28);
    master.write_reg(`RTC_ADDR_SQUARE_CONTROL, 8'h81);
    sq_edges(0);
    master.write_reg(`RTC_ADDR_TEST_CONTROL, 8'h00);
    for (int r = 0; r < 4; r++) begin
      master.write_reg(`RTC_ADDR_SQUARE_CONTROL, 8'h80 | 8'(r));
      check_reg(`RTC_ADDR_SQUARE_CONTROL, 8'h80 | 8'(r));
      sq_edges(sq_exp[r]);
    end
    master.write_reg(`RTC_ADDR_SQUARE_CONTROL, 8'h00);
    sq_edges(0);
    // Level interrupt from a 4096 Hz countdown of two
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h01);
    master.write_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'h02);
    check_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'h02);
    master.write_reg(`RTC_ADDR_COUNTDOWN_CONTROL, 8'h80);
    wait_irq(1'b1, 400, n);
    check8({7'h00, n > 62 && n <= 132}, 8'h01);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h05);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h05);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h05);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h04);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h04);
    check8({7'h00, irq_n_oe}, 8'h00);
    // Stop the countdown by a zero reload before clearing, so no expiry races the clear
    master.write_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'h00);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h00);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h00);
    repeat (300) @(posedge ref_clk);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h00);
    master.write_reg(`RTC_ADDR_COUNTDOWN_CONTROL, 8'h00);
    master.write_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'h01);
    repeat (300) @(posedge ref_clk);
    check_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'h01);
    // Pulse widths for reload one and two
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h11);
    master.write_reg(`RTC_ADDR_COUNTDOWN_CONTROL, 8'h80);
    for (int k = 1; k < 3; k++) begin
      master.write_reg(`RTC_ADDR_COUNTDOWN_VALUE, 8'(k));
      wait_irq(1'b0, 600, n);
      wait_irq(1'b1, 600, n);
      wait_irq(1'b0, 600, n);
      check8(8'(n), 8'(32 * k));
    end
    master.write_reg(`RTC_ADDR_COUNTDOWN_CONTROL, 8'h03);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h02);
    // Calendar rollover at the end of a century with a minute alarm
    osc_half = 40;
    master.write_reg(`RTC_ADDR_ALARM_MINUTE, 8'h00);
    for (int i = 0; i < 7; i++) master.write_reg(8'h02 + 8'(i), cal_set[i]);
    got = 8'h59;
    for (int i = 0; i < 70 && got === 8'h59; i++) begin
      repeat (1000) @(posedge ref_clk);
      master.snapshot();
      master.read_reg(`RTC_ADDR_SECONDS, got);
    end
    for (int i = 0; i < 7; i++) check_reg(8'h02 + 8'(i), cal_next[i]);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h0a);
    check8({7'h00, irq_n_oe}, 8'h01);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h0a);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h0a);
    master.write_reg(`RTC_ADDR_IRQ_CONTROL, 8'h02);
    check_reg(`RTC_ADDR_IRQ_CONTROL, 8'h02);
    check8({7'h00, irq_n_oe}, 8'h00);
    supply_low <= 1'b1;
    repeat (4) @(posedge ref_clk);
    supply_low <= 1'b0;
    master.snapshot();
    master.read_reg(`RTC_ADDR_SECONDS, got);
    check8(got & 8'h80, 8'h80);
    finish_test();
  end
endmodule // testbench
